// ==== inc/cies_pkg.sv ====
package cies_pkg;
   localparam int          CIES_GPR_N   = 16;
   localparam logic [23:0] CIES_LEN2    = 24'h000002;
   localparam logic [23:0] CIES_LEN4    = 24'h000004;
   localparam int          CIES_SGN_W   = 15;
   localparam int          CIES_SGN_B   = 7;
   localparam int          CIES_EXTC_LSB = 8;
   localparam logic [2:0]  CIES_EXTC_RST = 3'h0;
   localparam logic        CIES_WDT_RST = 1'b1;
   localparam logic [15:0] CIES_GPR_RST = 16'h0000;
   localparam logic [31:0] CIES_MD_RST  = 32'h00000000;
   localparam logic [23:0] CIES_TGT_RST = 24'h000000;

   typedef enum logic [4:0] {
      CIES_OP_NOP      = 5'b00000,
      CIES_OP_ADD      = 5'b00001,
      CIES_OP_ADDC     = 5'b00010,
      CIES_OP_SUB      = 5'b00011,
      CIES_OP_SUBC     = 5'b00100,
      CIES_OP_MUL      = 5'b00101,
      CIES_OP_DIV      = 5'b00110,
      CIES_OP_DIVL     = 5'b00111,
      CIES_OP_CPL      = 5'b01000,
      CIES_OP_NEG      = 5'b01001,
      CIES_OP_BITCOPY  = 5'b01010,
      CIES_OP_BYTEMOD  = 5'b01011,
      CIES_OP_CMPDEC   = 5'b01100,
      CIES_OP_CMPINC   = 5'b01101,
      CIES_OP_NORM     = 5'b01110,
      CIES_OP_ARITH_RIGHT_SHIFT_OP     = 5'b01111,
      CIES_OP_WIDEN    = 5'b10000,
      CIES_OP_JBONE    = 5'b10001,
      CIES_OP_JBZERO   = 5'b10010,
      CIES_OP_PUSH_THEN_CALL    = 5'b10011,
      CIES_OP_CTXSW    = 5'b10100,
      CIES_OP_TRAP     = 5'b10101,
      CIES_OP_LEGPWR   = 5'b10110,
      CIES_OP_WDT      = 5'b10111,
      CIES_OP_EXTSEG   = 5'b11000
   } cies_op_t;

   typedef struct packed {
      logic        valid;
      cies_op_t    op;
      logic        len4;
      logic        byte_sel;
      logic        sgn;
      logic        var_sel;
      logic [3:0]  rd;
      logic [3:0]  rs;
      logic [3:0]  bit_d;
      logic [3:0]  bit_s;
      logic [15:0] imm;
      logic [15:0] mem_data;
      logic [23:0] pc;
   } cies_req_t;

   typedef struct packed {
      logic        we;
      logic [3:0]  idx;
      logic [15:0] data;
   } cies_wb_t;

   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic c;
   } cies_flags_t;

   typedef struct packed {
      logic       active;
      logic       reg_mode;
      logic [7:0] seg;
   } cies_ext_t;
endpackage : cies_pkg

// ==== rtl/cies_core.sv ====
`timescale 1ns/100ps
module cies_core
   import cies_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire cies_req_t   req_i,
   output logic             done_o,
   output logic             illegal_o,
   output cies_wb_t         wb_o,
   output cies_flags_t      flags_o,
   output logic [31:0]      md_o,
   output logic             mem_we_o,
   output logic [15:0]      mem_data_o,
   output logic             branch_o,
   output logic [23:0]      target_o,
   output logic             push_o,
   output logic [15:0]      push_data_o,
   output logic             trap_o,
   output logic             wdt_en_o,
   output cies_ext_t        ext_o
);

   ////////////////////////////////////////////////////////////////////////
   // length legality per operation
   function automatic logic len_ok(input cies_op_t op, input logic len4);
      case (op)
         CIES_OP_MUL, CIES_OP_DIV, CIES_OP_DIVL, CIES_OP_CPL, CIES_OP_NEG,
         CIES_OP_NORM, CIES_OP_ARITH_RIGHT_SHIFT_OP, CIES_OP_TRAP: len_ok = !len4;
         CIES_OP_BITCOPY, CIES_OP_BYTEMOD, CIES_OP_JBONE, CIES_OP_JBZERO,
         CIES_OP_PUSH_THEN_CALL, CIES_OP_CTXSW, CIES_OP_LEGPWR, CIES_OP_WDT: len_ok = len4;
         default: len_ok = 1'b1;
      endcase
   endfunction : len_ok

   function automatic logic [15:0] put_bit(input logic [15:0] w, input logic [3:0] p, input logic b);
      logic [15:0] r;
      r    = w;
      r[p] = b;
      put_bit = r;
   endfunction : put_bit

   // leading zeros before bit 15 is one; zero word gives zero
   function automatic logic [15:0] norm_cnt(input logic [15:0] w);
      logic [15:0] c;
      logic        hit;
      c   = 16'h0000;
      hit = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         if (w[i]) begin
            hit = 1'b1;
         end else if (!hit) begin
            c = c + 16'h0001;
         end
      end
      norm_cnt = hit ? c : 16'h0000;
   endfunction : norm_cnt

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [15:0] gpr_r [CIES_GPR_N];
   logic        done_r, done_nxt, ill_r, ill_nxt;
   cies_wb_t    wb_r, wb_nxt;
   cies_flags_t flags_r, flags_nxt;
   logic [31:0] md_r, md_nxt;
   logic        mem_we_r, mem_we_nxt;
   logic [15:0] mem_data_r, mem_data_nxt;
   logic        br_r, br_nxt;
   logic [23:0] tgt_r, tgt_nxt;
   logic        push_r, push_nxt;
   logic [15:0] push_data_r, push_data_nxt;
   logic        trap_r, trap_nxt;
   logic        wdt_r, wdt_nxt;
   cies_ext_t   ext_r, ext_nxt;
   logic [2:0]  extc_r, extc_nxt;

   ////////////////////////////////////////////////////////////////////////
   // operand fetch and datapath
   // operands read the register file as it stood before this edge
   wire         go       = req_i.valid && len_ok(req_i.op, req_i.len4);
   wire [15:0]  opa      = gpr_r[req_i.rd];
   wire [15:0]  opr      = gpr_r[req_i.rs];
   wire [15:0]  opb      = req_i.len4 ? req_i.imm : opr;
   wire         is_sub   = (req_i.op == CIES_OP_SUB) || (req_i.op == CIES_OP_SUBC);
   // borrow doubles as carry for subtract, so one flag serves both chains
   wire         cin      = ((req_i.op == CIES_OP_ADDC) || (req_i.op == CIES_OP_SUBC)) && flags_r.c;
   wire [16:0]  sumw     = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
   wire [16:0]  difw     = {1'b0, opa} - {1'b0, opb} - {16'h0000, cin};
   wire [8:0]   sumb     = {1'b0, opa[7:0]} + {1'b0, opb[7:0]} + {8'h00, cin};
   wire [8:0]   difb     = {1'b0, opa[7:0]} - {1'b0, opb[7:0]} - {8'h00, cin};
   wire [16:0]  arw      = is_sub ? difw : sumw;
   wire [8:0]   arb      = is_sub ? difb : sumb;
   wire [15:0]  bsx      = is_sub ? ~opb : opb;
   wire         ovw      = (opa[CIES_SGN_W] == bsx[CIES_SGN_W]) && (arw[CIES_SGN_W] != opa[CIES_SGN_W]);
   wire         ovb      = (opa[CIES_SGN_B] == bsx[CIES_SGN_B]) && (arb[CIES_SGN_B] != opa[CIES_SGN_B]);
   wire [31:0]  prod_s   = 32'($signed(opa) * $signed(opr));
   wire [31:0]  prod_u   = 32'(opa) * 32'(opr);
   wire [31:0]  dvd      = (req_i.op == CIES_OP_DIVL) ? md_r :
                           {{16{req_i.sgn & md_r[CIES_SGN_W]}}, md_r[15:0]};
   wire [31:0]  dvs      = {{16{req_i.sgn & opr[CIES_SGN_W]}}, opr};
   // divide by zero is caught here and forces a zero quotient and remainder past the divider
   wire         dvz      = (opr == 16'h0000);
   wire [31:0]  quo      = dvz ? 32'h00000000 : req_i.sgn ? 32'($signed(dvd) / $signed(dvs)) : dvd / dvs;
   wire [31:0]  rem      = dvz ? 32'h00000000 : req_i.sgn ? 32'($signed(dvd) % $signed(dvs)) : dvd % dvs;
   // overflow is judged on the full quotient before it is cut to 16 bits
   wire         q_ovf    = req_i.sgn ? (quo[31:15] != {17{quo[CIES_SGN_W]}}) : (quo[31:16] != 16'h0000);
   wire [15:0]  cpl_w    = req_i.byte_sel ? {opa[15:8], ~opa[7:0]} : ~opa;
   wire [15:0]  neg_w    = req_i.byte_sel ? {opa[15:8], 8'(-opa[7:0])} : 16'(-opa);
   // bit positions are four bits wide, so they cannot leave the word
   wire         cp_bit   = opr[req_i.bit_s] ^ req_i.var_sel;
   // mask one takes the immediate bit, mask zero keeps the memory bit
   wire [7:0]   bf_src   = req_i.var_sel ? req_i.mem_data[15:8] : req_i.mem_data[7:0];
   wire [7:0]   bf_new   = (bf_src & ~req_i.imm[7:0]) | (req_i.imm[15:8] & req_i.imm[7:0]);
   wire [15:0]  bf_word  = req_i.var_sel ? {bf_new, req_i.mem_data[7:0]} : {req_i.mem_data[15:8], bf_new};
   wire [15:0]  step     = req_i.var_sel ? 16'h0002 : 16'h0001;
   wire [16:0]  cmp_d    = {1'b0, opa} - {1'b0, opb};
   wire [3:0]   sh_amt   = req_i.var_sel ? req_i.bit_s : opr[3:0];
   wire [15:0]  arith_right_shift_op_w   = 16'($signed(opa) >>> sh_amt);
   wire [7:0]   wsrc     = req_i.len4 ? req_i.mem_data[7:0] : opr[7:0];
   wire [15:0]  widen_w  = {{8{req_i.sgn & wsrc[CIES_SGN_B]}}, wsrc};
   wire         tbit     = opa[req_i.bit_d];
   wire         jtake    = (req_i.op == CIES_OP_JBONE) ? tbit : !tbit;
   // relative offset counts words from the following instruction
   wire [23:0]  next_pc  = req_i.pc + (req_i.len4 ? CIES_LEN4 : CIES_LEN2);
   wire [23:0]  rel_tgt  = next_pc + {{15{req_i.imm[7]}}, req_i.imm[7:0], 1'b0};
   wire [23:0]  abs_tgt  = {req_i.pc[23:16], req_i.imm};
   // vector table spaced four bytes apart
   wire [23:0]  trap_tgt = {15'h0000, req_i.imm[6:0], 2'b00};

   ////////////////////////////////////////////////////////////////////////
   // execute
   always_comb begin
      done_nxt      = go;
      ill_nxt       = req_i.valid && !go;
      wb_nxt        = '{we: 1'b0, idx: req_i.rd, data: 16'h0000};
      flags_nxt     = flags_r;
      md_nxt        = md_r;
      mem_we_nxt    = 1'b0;
      mem_data_nxt  = mem_data_r;
      br_nxt        = 1'b0;
      tgt_nxt       = tgt_r;
      push_nxt      = 1'b0;
      push_data_nxt = push_data_r;
      trap_nxt      = 1'b0;
      wdt_nxt       = wdt_r;
      ext_nxt       = ext_r;
      extc_nxt      = extc_r;
      // each following legal instruction uses up one slot of the open sequence
      if (go && ext_r.active) begin
         extc_nxt = extc_r - 3'h1;
         if (extc_r == 3'h1) begin
            ext_nxt.active = 1'b0;
         end
      end
      if (go) begin
         // opcode codes are our own; the enum is the single place to remap them
         case (req_i.op)
            CIES_OP_ADD, CIES_OP_ADDC, CIES_OP_SUB, CIES_OP_SUBC: begin
               wb_nxt.we   = 1'b1;
               wb_nxt.data = req_i.byte_sel ? {opa[15:8], arb[7:0]} : arw[15:0];
               flags_nxt.c = req_i.byte_sel ? arb[8] : arw[16];
               flags_nxt.v = req_i.byte_sel ? ovb : ovw;
               flags_nxt.n = req_i.byte_sel ? arb[CIES_SGN_B] : arw[CIES_SGN_W];
               flags_nxt.z = req_i.byte_sel ? (arb[7:0] == 8'h00) : (arw[15:0] == 16'h0000);
            end
            CIES_OP_MUL: begin
               md_nxt      = req_i.sgn ? prod_s : prod_u;
               flags_nxt.z = (md_nxt == 32'h00000000);
               flags_nxt.n = md_nxt[31];
            end
            CIES_OP_DIV, CIES_OP_DIVL: begin
               // divide by zero or overflow leaves the register untouched
               flags_nxt.v = dvz || q_ovf;
               if (!dvz && !q_ovf) begin
                  md_nxt      = {rem[15:0], quo[15:0]};
                  flags_nxt.z = (quo[15:0] == 16'h0000);
                  flags_nxt.n = quo[CIES_SGN_W];
               end
            end
            CIES_OP_CPL, CIES_OP_NEG: begin
               wb_nxt.we   = 1'b1;
               wb_nxt.data = (req_i.op == CIES_OP_CPL) ? cpl_w : neg_w;
            end
            CIES_OP_BITCOPY: begin
               wb_nxt.we   = 1'b1;
               wb_nxt.data = put_bit(opa, req_i.bit_d, cp_bit);
            end
            CIES_OP_BYTEMOD: begin
               mem_we_nxt   = 1'b1;
               mem_data_nxt = bf_word;
            end
            CIES_OP_CMPDEC, CIES_OP_CMPINC: begin
               flags_nxt.c = cmp_d[16];
               flags_nxt.z = (cmp_d[15:0] == 16'h0000);
               flags_nxt.n = cmp_d[CIES_SGN_W];
               wb_nxt.we   = 1'b1;
               wb_nxt.data = (req_i.op == CIES_OP_CMPDEC) ? opa - step : opa + step;
            end
            CIES_OP_NORM: begin
               wb_nxt.we   = 1'b1;
               wb_nxt.data = norm_cnt(opr);
               flags_nxt.z = (opr == 16'h0000);
            end
            CIES_OP_ARITH_RIGHT_SHIFT_OP: begin
               wb_nxt.we   = 1'b1;
               wb_nxt.data = arith_right_shift_op_w;
            end
            CIES_OP_WIDEN: begin
               wb_nxt.we   = 1'b1;
               wb_nxt.data = widen_w;
            end
            CIES_OP_JBONE, CIES_OP_JBZERO: begin
               br_nxt = jtake;
               if (jtake) begin
                  tgt_nxt = rel_tgt;
               end
               wb_nxt.we   = jtake && req_i.var_sel;
               wb_nxt.data = put_bit(opa, req_i.bit_d, req_i.op == CIES_OP_JBZERO);
            end
            CIES_OP_PUSH_THEN_CALL: begin
               push_nxt      = 1'b1;
               push_data_nxt = opa;
               br_nxt        = 1'b1;
               tgt_nxt       = abs_tgt;
            end
            CIES_OP_CTXSW: begin
               push_nxt      = 1'b1;
               push_data_nxt = opa;
               wb_nxt.we     = 1'b1;
               wb_nxt.data   = req_i.var_sel ? req_i.mem_data : req_i.imm;
            end
            CIES_OP_TRAP: begin
               trap_nxt = 1'b1;
               br_nxt   = 1'b1;
               tgt_nxt  = trap_tgt;
            end
            CIES_OP_WDT: begin
               wdt_nxt = req_i.var_sel;
            end
            CIES_OP_EXTSEG: begin
               ext_nxt  = '{active: 1'b1, reg_mode: req_i.var_sel, seg: req_i.len4 ? req_i.imm[7:0] : opr[7:0]};
               // count field holds slots minus one: one to four following instructions
               extc_nxt = {1'b0, req_i.imm[CIES_EXTC_LSB +: 2]} + 3'h1;
            end
            // accepted and retired with no side effect
            CIES_OP_LEGPWR: begin
               done_nxt = 1'b1;
            end
            default: begin
               done_nxt = 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers; one instruction retires per cycle, no stall path
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_r      <= 1'b0;
         ill_r       <= 1'b0;
         wb_r        <= '0;
         flags_r     <= '0;
         md_r        <= CIES_MD_RST;
         mem_we_r    <= 1'b0;
         mem_data_r  <= CIES_GPR_RST;
         br_r        <= 1'b0;
         tgt_r       <= CIES_TGT_RST;
         push_r      <= 1'b0;
         push_data_r <= CIES_GPR_RST;
         trap_r      <= 1'b0;
         wdt_r       <= CIES_WDT_RST;
         ext_r       <= '0;
         extc_r      <= CIES_EXTC_RST;
      end else begin
         done_r      <= done_nxt;
         ill_r       <= ill_nxt;
         wb_r        <= wb_nxt;
         flags_r     <= flags_nxt;
         md_r        <= md_nxt;
         mem_we_r    <= mem_we_nxt;
         mem_data_r  <= mem_data_nxt;
         br_r        <= br_nxt;
         tgt_r       <= tgt_nxt;
         push_r      <= push_nxt;
         push_data_r <= push_data_nxt;
         trap_r      <= trap_nxt;
         wdt_r       <= wdt_nxt;
         ext_r       <= ext_nxt;
         extc_r      <= extc_nxt;
      end
   end

   // register file written in the same edge that publishes the write-back
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < CIES_GPR_N; i++) begin
            gpr_r[i] <= CIES_GPR_RST;
         end
      end else if (wb_nxt.we) begin
         gpr_r[wb_nxt.idx] <= wb_nxt.data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign done_o      = done_r;
   assign illegal_o   = ill_r;
   assign wb_o        = wb_r;
   assign flags_o     = flags_r;
   assign md_o        = md_r;
   assign mem_we_o    = mem_we_r;
   assign mem_data_o  = mem_data_r;
   assign branch_o    = br_r;
   assign target_o    = tgt_r;
   assign push_o      = push_r;
   assign push_data_o = push_data_r;
   assign trap_o      = trap_r;
   assign wdt_en_o    = wdt_r;
   assign ext_o       = ext_r;

endmodule : cies_core

// ==== testbench/cies_fetch_model.sv ====
`timescale 1ns/100ps
module cies_fetch_model
   import cies_pkg::*;
(
   input  wire logic      mclk_i,
   input  wire logic      rst_n_i,
   input  wire cies_req_t next_i,
   output cies_req_t      req_o
);
   // idle slots hold valid low and keep toggling every other field so the core cannot lean on stale data
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         req_o <= '0;
      else if (next_i.valid)
         req_o <= next_i;
      else
         req_o <= cies_req_t'({1'b0, ~req_o[$bits(cies_req_t)-2:0]});
   end
endmodule : cies_fetch_model

// ==== testbench/cies_core_asserts.sv ====
`timescale 1ns/100ps
module cies_core_asserts
   import cies_pkg::*;
(
   input wire logic        mclk_i,
   input wire logic        rst_n_i,
   input wire cies_req_t   req_i,
   input wire logic        done_o,
   input wire logic        illegal_o,
   input wire cies_wb_t    wb_o,
   input wire cies_flags_t flags_o,
   input wire logic [31:0] md_o,
   input wire logic        mem_we_o,
   input wire logic [15:0] mem_data_o,
   input wire logic        branch_o,
   input wire logic [23:0] target_o,
   input wire logic        push_o,
   input wire logic [15:0] push_data_o,
   input wire logic        trap_o,
   input wire logic        wdt_en_o,
   input wire cies_ext_t   ext_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   wire [7:0]  bm_m  = req_i.imm[7:0];
   wire [7:0]  bm_hi = (req_i.mem_data[15:8] & ~bm_m) | (req_i.imm[15:8] & bm_m);
   wire [7:0]  bm_lo = (req_i.mem_data[7:0] & ~bm_m) | (req_i.imm[15:8] & bm_m);
   wire [15:0] bm_exp = req_i.var_sel ? {bm_hi, req_i.mem_data[7:0]} : {req_i.mem_data[15:8], bm_lo};
   wire [15:0] wd_exp = {{8{req_i.sgn & req_i.mem_data[7]}}, req_i.mem_data[7:0]};
   ////////////////////////////////////////////////////////////
   sequence s_go(cies_op_t op, logic l4);
      req_i.valid && req_i.op == op && req_i.len4 == l4;
   endsequence
   sequence s_call;
      push_o && branch_o;
   endsequence
   chk_add_retire: assert property (s_go(CIES_OP_ADD, 1'b0) |=> done_o && !illegal_o && wb_o.we)
      else $error("add did not retire");
   chk_mul_form: assert property (s_go(CIES_OP_MUL, 1'b1) |=> illegal_o && !done_o && !wb_o.we && $stable(md_o))
      else $error("long multiply form not refused");
   chk_trap_vector: assert property (s_go(CIES_OP_TRAP, 1'b0) |=> trap_o && branch_o
      && target_o == {15'h0000, $past(req_i.imm[6:0]), 2'b00})
      else $error("trap vector wrong");
   chk_push_then_call_seq: assert property (s_go(CIES_OP_PUSH_THEN_CALL, 1'b1) |=> s_call ##0
      target_o == {$past(req_i.pc[23:16]), $past(req_i.imm)})
      else $error("push and call wrong");
   chk_ctxsw_load: assert property (s_go(CIES_OP_CTXSW, 1'b1) |=> push_o && wb_o.we && wb_o.idx == $past(req_i.rd)
      && wb_o.data == ($past(req_i.var_sel) ? $past(req_i.mem_data) : $past(req_i.imm)))
      else $error("context switch load wrong");
   chk_pwr_noop: assert property (s_go(CIES_OP_LEGPWR, 1'b1) |=> done_o && !wb_o.we && !mem_we_o
      && !branch_o && !push_o && !trap_o)
      else $error("power-down opcode had an effect");
   chk_wdt_level: assert property (s_go(CIES_OP_WDT, 1'b1) |=> wdt_en_o == $past(req_i.var_sel))
      else $error("watchdog enable wrong");
   chk_byte_mod: assert property (s_go(CIES_OP_BYTEMOD, 1'b1) |=> mem_we_o && mem_data_o == $past(bm_exp))
      else $error("masked byte modify wrong");
   chk_widen_mem: assert property (s_go(CIES_OP_WIDEN, 1'b1) |=> wb_o.we && wb_o.data == $past(wd_exp))
      else $error("byte widen wrong");
   chk_ext_open: assert property (s_go(CIES_OP_EXTSEG, 1'b1) |=> ext_o.active
      && ext_o.reg_mode == $past(req_i.var_sel) && ext_o.seg == $past(req_i.imm[7:0]))
      else $error("extended sequence not opened");
endmodule : cies_core_asserts

// ==== testbench/cies_core_tb.sv ====
`timescale 1ns/100ps
module cies_core_tb;
   import cies_pkg::*;
   logic        mclk_i, rst_n_i, done_o, illegal_o, mem_we_o, branch_o, push_o, trap_o, wdt_en_o;
   logic [15:0] mem_data_o, push_data_o;
   logic [23:0] target_o;
   logic [31:0] md_o;
   cies_req_t   req_i, nxt;
   cies_wb_t    wb_o;
   cies_flags_t flags_o;
   cies_ext_t   ext_o;
   int          num_errors, n_tests;
   cies_core        cies_core_i (.*);
   cies_fetch_model cies_fetch_model_i (.mclk_i, .rst_n_i, .next_i(nxt), .req_o(req_i));
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   ////////////////////////////////////////////////////////////
   task automatic final_report();
      if (num_errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   function automatic cies_req_t rq(cies_op_t op, logic l4, logic vs, logic [3:0] rd, logic [3:0] rs, logic [15:0] im);
      return '{1'b1, op, l4, 1'b0, 1'b0, vs, rd, rs, 4'h0, 4'h0, im, 16'h0000, 24'h000000};
   endfunction : rq
   // the fetch model adds one stage, so the result lands two edges after launch
   task automatic run(input cies_req_t r);
      @(posedge mclk_i);
      nxt <= r;
      @(posedge mclk_i);
      nxt.valid <= 1'b0;
      @(posedge mclk_i);
      #1;
   endtask : run
   task automatic wbx(input cies_req_t r, input logic [15:0] exp);
      run(r);
      cmp({done_o, wb_o.we, wb_o.data}, {2'b11, exp});
   endtask : wbx
   task automatic ld(input logic [3:0] rd, input logic [15:0] v);
      run(rq(CIES_OP_CTXSW, 1'b1, 1'b0, rd, 4'h0, v));
   endtask : ld
   ////////////////////////////////////////////////////////////
   task automatic t_arith();
      cies_req_t r;
      ld(4'h1, 16'hFFFF);
      ld(4'h2, 16'h0001);
      wbx(rq(CIES_OP_ADD, 1'b0, 1'b0, 4'h1, 4'h2, 16'h0000), 16'h0000);
      cmp(flags_o.c, 1'b1);
      wbx(rq(CIES_OP_ADDC, 1'b1, 1'b0, 4'h1, 4'h0, 16'h0000), 16'h0001);
      wbx(rq(CIES_OP_SUB, 1'b1, 1'b0, 4'h1, 4'h0, 16'h0002), 16'hFFFF);
      wbx(rq(CIES_OP_SUBC, 1'b1, 1'b0, 4'h1, 4'h0, 16'h0000), 16'hFFFE);
      r = rq(CIES_OP_ADD, 1'b1, 1'b0, 4'h1, 4'h0, 16'h0002);
      r.byte_sel = 1'b1;
      wbx(r, 16'hFF00);
   endtask : t_arith
   task automatic t_muldiv();
      cies_req_t r;
      ld(4'h3, 16'hFFFE);
      ld(4'h4, 16'h0003);
      r = rq(CIES_OP_MUL, 1'b0, 1'b0, 4'h3, 4'h4, 16'h0000);
      r.sgn = 1'b1;
      run(r);
      cmp(md_o, 32'hFFFFFFFA);
      r.sgn = 1'b0;
      run(r);
      cmp(md_o, 32'h0002FFFA);
      r.len4 = 1'b1;
      run(r);
      cmp({illegal_o, done_o, md_o}, {2'b10, 32'h0002FFFA});
      run(rq(CIES_OP_DIVL, 1'b0, 1'b0, 4'h4, 4'h4, 16'h0000));
      cmp(md_o, 32'h0000FFFE);
      run(rq(CIES_OP_DIV, 1'b0, 1'b0, 4'h4, 4'h4, 16'h0000));
      cmp(md_o, 32'h00025554);
      run(rq(CIES_OP_DIV, 1'b0, 1'b0, 4'h4, 4'h0, 16'h0000));
      cmp({flags_o.v, md_o}, {1'b1, 32'h00025554});
      wbx(rq(CIES_OP_CPL, 1'b0, 1'b0, 4'h4, 4'h0, 16'h0000), 16'hFFFC);
      wbx(rq(CIES_OP_NEG, 1'b0, 1'b0, 4'h4, 4'h0, 16'h0000), 16'h0004);
      r = rq(CIES_OP_CPL, 1'b0, 1'b0, 4'h4, 4'h0, 16'h0000);
      r.byte_sel = 1'b1;
      wbx(r, 16'h00FB);
   endtask : t_muldiv
   task automatic t_bits();
      cies_req_t r;
      ld(4'h5, 16'hFFFF);
      r = rq(CIES_OP_BITCOPY, 1'b1, 1'b1, 4'h5, 4'h1, 16'h0000);
      r.bit_d = 4'hF;
      r.bit_s = 4'h8;
      wbx(r, 16'h7FFF);
      wbx(rq(CIES_OP_CMPDEC, 1'b1, 1'b1, 4'h5, 4'h0, 16'h7FFF), 16'h7FFD);
      cmp(flags_o.z, 1'b1);
      wbx(rq(CIES_OP_CMPINC, 1'b1, 1'b0, 4'h5, 4'h0, 16'h0000), 16'h7FFE);
      wbx(rq(CIES_OP_NORM, 1'b0, 1'b0, 4'h6, 4'h5, 16'h0000), 16'h0001);
      ld(4'h7, 16'h8000);
      r = rq(CIES_OP_ARITH_RIGHT_SHIFT_OP, 1'b0, 1'b1, 4'h7, 4'h0, 16'h0000);
      r.bit_s = 4'h4;
      wbx(r, 16'hF800);
      ld(4'h9, 16'h9000);
      r = rq(CIES_OP_ARITH_RIGHT_SHIFT_OP, 1'b0, 1'b0, 4'h9, 4'h4, 16'h0000);
      wbx(r, 16'hFFF2);
      r = rq(CIES_OP_WIDEN, 1'b0, 1'b0, 4'h8, 4'h5, 16'h0000);
      r.sgn = 1'b1;
      wbx(r, 16'hFFFE);
      r.len4 = 1'b1;
      r.sgn = 1'b0;
      r.mem_data = 16'h0080;
      wbx(r, 16'h0080);
      r = rq(CIES_OP_BYTEMOD, 1'b1, 1'b1, 4'h0, 4'h0, 16'hAB0F);
      r.mem_data = 16'h1234;
      run(r);
      cmp({mem_we_o, mem_data_o}, {1'b1, 16'h1B34});
      r.var_sel = 1'b0;
      run(r);
      cmp({mem_we_o, mem_data_o}, {1'b1, 16'h123B});
   endtask : t_bits
   task automatic t_flow();
      cies_req_t r;
      r = rq(CIES_OP_JBONE, 1'b1, 1'b1, 4'h7, 4'h0, 16'h00FE);
      r.bit_d = 4'hF;
      r.pc = 24'h000100;
      wbx(r, 16'h7800);
      cmp({branch_o, target_o}, {1'b1, 24'h000100});
      r.op = CIES_OP_JBZERO;
      wbx(r, 16'hF800);
      cmp({branch_o, target_o}, {1'b1, 24'h000100});
      run(r);
      cmp(branch_o, 1'b0);
      r.op = CIES_OP_JBONE;
      r.bit_d = 4'h3;
      run(r);
      cmp(branch_o, 1'b0);
      r = rq(CIES_OP_PUSH_THEN_CALL, 1'b1, 1'b0, 4'h7, 4'h0, 16'h4000);
      r.pc = 24'h120000;
      run(r);
      cmp({push_o, push_data_o}, {1'b1, 16'hF800});
      cmp({branch_o, target_o}, {1'b1, 24'h124000});
      r = rq(CIES_OP_CTXSW, 1'b1, 1'b1, 4'h7, 4'h0, 16'h0000);
      r.mem_data = 16'h5A5A;
      wbx(r, 16'h5A5A);
      cmp({push_o, push_data_o}, {1'b1, 16'hF800});
      run(rq(CIES_OP_TRAP, 1'b0, 1'b0, 4'h0, 4'h0, 16'h007F));
      cmp({trap_o, branch_o, target_o}, {2'b11, 24'h0001FC});
   endtask : t_flow
   task automatic t_sys();
      run(rq(CIES_OP_LEGPWR, 1'b1, 1'b0, 4'h0, 4'h0, 16'h0000));
      cmp({done_o, wb_o.we, mem_we_o, branch_o, push_o}, 5'b10000);
      run(rq(CIES_OP_LEGPWR, 1'b0, 1'b0, 4'h0, 4'h0, 16'h0000));
      cmp(illegal_o, 1'b1);
      run(rq(CIES_OP_EXTSEG, 1'b1, 1'b1, 4'h0, 4'h0, 16'h0055));
      cmp(ext_o, {2'b11, 8'h55});
      run(rq(CIES_OP_NOP, 1'b0, 1'b0, 4'h0, 4'h0, 16'h0000));
      cmp(ext_o.active, 1'b0);
      run(rq(CIES_OP_EXTSEG, 1'b0, 1'b0, 4'h0, 4'h4, 16'h0100));
      cmp(ext_o, {2'b10, 8'hFB});
      run(rq(CIES_OP_NOP, 1'b0, 1'b0, 4'h0, 4'h0, 16'h0000));
      cmp(ext_o.active, 1'b1);
      run(rq(CIES_OP_NOP, 1'b0, 1'b0, 4'h0, 4'h0, 16'h0000));
      cmp(ext_o.active, 1'b0);
      cmp(wdt_en_o, 1'b1);
      run(rq(CIES_OP_WDT, 1'b1, 1'b0, 4'h0, 4'h0, 16'h0000));
      cmp(wdt_en_o, 1'b0);
      run(rq(CIES_OP_WDT, 1'b1, 1'b1, 4'h0, 4'h0, 16'h0000));
      cmp(wdt_en_o, 1'b1);
      run(rq(CIES_OP_WDT, 1'b1, 1'b0, 4'h0, 4'h0, 16'h0000));
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      cmp({wdt_en_o, md_o}, {1'b1, 32'h00000000});
      @(posedge mclk_i);
      rst_n_i <= 1'b1;
   endtask : t_sys
   ////////////////////////////////////////////////////////////
   initial begin
      rst_n_i = 1'b0;
      nxt = '0;
      num_errors = 0;
      n_tests = 0;
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_arith();
      t_muldiv();
      t_bits();
      t_flow();
      t_sys();
      final_report();
   end
   // every wait is fixed, so this only trips if the sequence itself stalls
   initial begin
      repeat (3000) @(posedge mclk_i);
      num_errors++;
      final_report();
   end
endmodule : cies_core_tb
bind cies_core cies_core_asserts cies_core_asserts_i (.*);
